// >>> verilog/mss_params.svh
`ifndef MSS_PARAMS_SVH
`define MSS_PARAMS_SVH

// core clock and the fast rundown time base
`define MSS_CORE_CLK_HZ     10000000
`define MSS_RUNDOWN_CLK_HZ  4000000

// charge period window in milliseconds, and in core clock cycles
`define MSS_CHARGE_MIN_MS   20
`define MSS_CHARGE_MAX_MS   200
`define MSS_CHARGE_MIN_CYC  (`MSS_CHARGE_MIN_MS * (`MSS_CORE_CLK_HZ / 1000))
`define MSS_CHARGE_MAX_CYC  (`MSS_CHARGE_MAX_MS * (`MSS_CORE_CLK_HZ / 1000))

// length of one fixed discharge pulse in core clock cycles
`define MSS_DISCHARGE_CYC   16

// vernier current is full current divided by this ratio
`define MSS_VERNIER_RATIO   128

// result counter width and test period counter width
`define MSS_CNT_W           24
`define MSS_PER_W           22

`endif

// >>> verilog/mss_pkg.sv
`include "mss_params.svh"

package mss_pkg;

  // gray order along idle, charge, fast rundown, vernier rundown
  typedef enum logic [1:0] {
    MSS_IDLE   = 2'h0,
    MSS_CHARGE = 2'h1,
    MSS_FAST   = 2'h3,
    MSS_SLOW   = 2'h2
  } mss_state_t;

  typedef enum logic [1:0] {
    MSS_PH_OFFSET = 2'h0,
    MSS_PH_INPH   = 2'h1,
    MSS_PH_QUAD   = 2'h2
  } mss_phase_t;

  typedef struct packed {
    logic [`MSS_CNT_W-1:0] pulses;
    logic [`MSS_CNT_W-1:0] fast;
    logic [`MSS_CNT_W-1:0] vernier;
  } mss_result_t;

endpackage

// >>> verilog/mss_counter.sv
module mss_counter #(
  parameter int unsigned W = 24
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         clr,
  input  wire logic         en,
  output logic      [W-1:0] count
);

  // saturates rather than wraps so an overrange reads as full scale
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (clr) begin
      count <= '0;
    end else if (en && !(&count)) begin
      count <= count + W'(1);
    end
  end

endmodule

// >>> verilog/mss_sequencer.sv
`include "mss_params.svh"

module mss_sequencer
  import mss_pkg::*;
#(
  parameter int unsigned CHARGE_MIN_CYC           = `MSS_CHARGE_MIN_CYC,
  parameter int unsigned CHARGE_MAX_CYC           = `MSS_CHARGE_MAX_CYC,
  parameter int unsigned FIXED_DISCHARGE_INTERVAL = `MSS_DISCHARGE_CYC
) (
  input  wire logic                   CORE_CLK,
  input  wire logic                   RESET,
  input  wire logic                   START,
  input  wire logic                   RESULT_ACK,
  input  wire logic [`MSS_PER_W-1:0]  TEST_PERIOD_CYC,
  input  wire logic [1:0]             RESULT_SEL,
  input  wire logic                   UPPER_THRESHOLD_COMPARATOR,
  input  wire logic                   VERNIER_THRESHOLD_COMPARATOR,
  input  wire logic                   BASELINE_REACHED,
  output logic                        INTEGRATE,
  output logic                        DISCHARGE_CURRENT_SOURCE,
  output logic                        DISCHARGE_SLOW,
  output logic                        BUSY,
  output logic                        DONE,
  output logic                        RANGE_ERR,
  output mss_phase_t                  PHASE,
  output mss_result_t                 RESULT
);

  localparam int unsigned CW     = $clog2(CHARGE_MAX_CYC + 1);
  localparam int unsigned TW     = $clog2(FIXED_DISCHARGE_INTERVAL + 1);
  localparam int unsigned PW     = `MSS_PER_W;
  localparam logic [23:0] RD_STEP = 24'(`MSS_RUNDOWN_CLK_HZ);
  localparam logic [23:0] RD_MOD  = 24'(`MSS_CORE_CLK_HZ);

  mss_state_t          state;
  logic [CW-1:0]       charge_cnt;
  logic [PW-1:0]       period_cnt;
  logic [PW-1:0]       period_len;
  logic [TW-1:0]       td_cnt;
  logic [23:0]         rd_acc;
  logic                rd_tick;
  logic                start_ok;
  logic                pulse_go;
  logic                period_end;
  logic                charge_done;
  logic                conv_end;
  logic                conv_clr;
  logic [`MSS_CNT_W-1:0] cnt_pulse;
  logic [`MSS_CNT_W-1:0] cnt_fast;
  logic [`MSS_CNT_W-1:0] cnt_vern;
  mss_result_t         res [0:2];

  // longest period still fits one whole period inside the window
  assign start_ok    = START && (state == MSS_IDLE) && !DONE && (TEST_PERIOD_CYC != '0)
                       && (TEST_PERIOD_CYC <= PW'(CHARGE_MAX_CYC - CHARGE_MIN_CYC));
  assign period_end  = (period_cnt == period_len - PW'(1));
  assign charge_done = INTEGRATE && period_end
                       && ((charge_cnt + CW'(1)) >= CW'(CHARGE_MIN_CYC));
  assign pulse_go    = (state == MSS_CHARGE) && INTEGRATE && !DISCHARGE_CURRENT_SOURCE
                       && UPPER_THRESHOLD_COMPARATOR;
  assign conv_end    = ((state == MSS_SLOW) || (state == MSS_FAST)) && BASELINE_REACHED;
  assign conv_clr    = start_ok || (conv_end && (PHASE != MSS_PH_QUAD));

  // fractional accumulator gives a 4 MHz tick from the 10 MHz core clock
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      rd_acc <= 24'h000000;
    end else if (state == MSS_CHARGE) begin
      rd_acc <= 24'h000000;
    end else if (rd_acc + RD_STEP >= RD_MOD) begin
      rd_acc <= rd_acc + RD_STEP - RD_MOD;
    end else begin
      rd_acc <= rd_acc + RD_STEP;
    end
  end
  assign rd_tick = (rd_acc + RD_STEP >= RD_MOD);

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      RANGE_ERR <= 1'b0;
    end else if (START && (state == MSS_IDLE) && !DONE) begin
      RANGE_ERR <= !start_ok;
    end
  end

  // charge timing in whole test periods
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      period_len <= '0;
      period_cnt <= '0;
      charge_cnt <= '0;
    end else if (conv_clr) begin
      if (start_ok) begin
        period_len <= TEST_PERIOD_CYC;
      end
      period_cnt <= '0;
      charge_cnt <= '0;
    end else if (INTEGRATE) begin
      period_cnt <= period_end ? '0 : period_cnt + PW'(1);
      charge_cnt <= charge_cnt + CW'(1);
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      INTEGRATE <= 1'b0;
    end else if (conv_clr) begin
      INTEGRATE <= 1'b1;
    end else if (charge_done) begin
      INTEGRATE <= 1'b0;
    end
  end

  // discharge switch: fixed pulses during charge, held on through rundown
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      DISCHARGE_CURRENT_SOURCE <= 1'b0;
      td_cnt                   <= '0;
    end else if (pulse_go) begin
      DISCHARGE_CURRENT_SOURCE <= 1'b1;
      td_cnt                   <= TW'(FIXED_DISCHARGE_INTERVAL - 1);
    end else if (state == MSS_CHARGE && DISCHARGE_CURRENT_SOURCE) begin
      if (td_cnt == '0) begin
        DISCHARGE_CURRENT_SOURCE <= 1'b0;
      end else begin
        td_cnt <= td_cnt - TW'(1);
      end
    end else if (state == MSS_CHARGE && !INTEGRATE) begin
      DISCHARGE_CURRENT_SOURCE <= 1'b1;
    end else if (conv_end) begin
      DISCHARGE_CURRENT_SOURCE <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      DISCHARGE_SLOW <= 1'b0;
    end else if (conv_end) begin
      DISCHARGE_SLOW <= 1'b0;
    end else if (state == MSS_FAST && VERNIER_THRESHOLD_COMPARATOR) begin
      DISCHARGE_SLOW <= 1'b1;
    end
  end

  // rundown only starts once a pending pulse has run its full length
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      state <= MSS_IDLE;
    end else begin
      unique case (state)
        MSS_IDLE: begin
          if (start_ok) begin
            state <= MSS_CHARGE;
          end
        end
        MSS_CHARGE: begin
          if (!INTEGRATE && !DISCHARGE_CURRENT_SOURCE) begin
            state <= MSS_FAST;
          end
        end
        MSS_FAST: begin
          if (conv_end) begin
            state <= (PHASE == MSS_PH_QUAD) ? MSS_IDLE : MSS_CHARGE;
          end else if (VERNIER_THRESHOLD_COMPARATOR) begin
            state <= MSS_SLOW;
          end
        end
        MSS_SLOW: begin
          if (conv_end) begin
            state <= (PHASE == MSS_PH_QUAD) ? MSS_IDLE : MSS_CHARGE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      PHASE <= MSS_PH_OFFSET;
    end else if (start_ok) begin
      PHASE <= MSS_PH_OFFSET;
    end else if (conv_end && PHASE != MSS_PH_QUAD) begin
      PHASE <= mss_phase_t'(PHASE + 2'h1);
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      BUSY <= 1'b0;
    end else if (start_ok) begin
      BUSY <= 1'b1;
    end else if (conv_end && PHASE == MSS_PH_QUAD) begin
      BUSY <= 1'b0;
    end
  end

  // completion wins over an acknowledge in the same cycle
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      DONE <= 1'b0;
    end else if (conv_end && PHASE == MSS_PH_QUAD) begin
      DONE <= 1'b1;
    end else if (RESULT_ACK) begin
      DONE <= 1'b0;
    end
  end

  mss_counter #(.W(`MSS_CNT_W)) u_cnt_pulse (.clk(CORE_CLK), .rst(RESET), .clr(conv_clr), .en(pulse_go),
    .count(cnt_pulse));
  mss_counter #(.W(`MSS_CNT_W)) u_cnt_fast (.clk(CORE_CLK), .rst(RESET), .clr(conv_clr),
    .en(state == MSS_FAST && rd_tick && !BASELINE_REACHED), .count(cnt_fast));
  mss_counter #(.W(`MSS_CNT_W)) u_cnt_vern (.clk(CORE_CLK), .rst(RESET), .clr(conv_clr),
    .en(state == MSS_SLOW && rd_tick && !BASELINE_REACHED), .count(cnt_vern));

  // one stored set per conversion cycle; restart is refused while DONE is up
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      for (int i = 0; i < 3; i++) begin
        res[i] <= '0;
      end
    end else if (conv_end) begin
      res[PHASE] <= '{pulses: cnt_pulse, fast: cnt_fast, vernier: cnt_vern};
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      RESULT <= '0;
    end else begin
      RESULT <= (RESULT_SEL == 2'h3) ? '0 : res[RESULT_SEL];
    end
  end

  // checks
  logic [TW:0] sw_len;
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      sw_len <= '0;
    end else if (pulse_go) begin
      sw_len <= '0;
    end else if (DISCHARGE_CURRENT_SOURCE && state == MSS_CHARGE) begin
      sw_len <= sw_len + (TW + 1)'(1);
    end
  end

  chk_pulse_width: assert property (@(posedge CORE_CLK) disable iff (RESET)
    $fell(DISCHARGE_CURRENT_SOURCE) && $past(state) == MSS_CHARGE |-> sw_len == (TW + 1)'(FIXED_DISCHARGE_INTERVAL))
    else $error("discharge pulse length wrong");
  chk_pulse_counted: assert property (@(posedge CORE_CLK) disable iff (RESET)
    pulse_go && !(&cnt_pulse) |=> cnt_pulse == $past(cnt_pulse) + `MSS_CNT_W'(1))
    else $error("discharge pulse not counted");
  chk_upper_closes: assert property (@(posedge CORE_CLK) disable iff (RESET)
    pulse_go |=> DISCHARGE_CURRENT_SOURCE && state == MSS_CHARGE)
    else $error("switch not closed on upper threshold");
  chk_charge_window: assert property (@(posedge CORE_CLK) disable iff (RESET)
    $fell(INTEGRATE) |-> charge_cnt >= CW'(CHARGE_MIN_CYC) && charge_cnt <= CW'(CHARGE_MAX_CYC) && period_cnt == '0)
    else $error("charge period outside window");
  chk_no_cross: assert property (@(posedge CORE_CLK) disable iff (RESET)
    state == MSS_CHARGE && INTEGRATE && !DISCHARGE_CURRENT_SOURCE && !UPPER_THRESHOLD_COMPARATOR
    |=> !DISCHARGE_CURRENT_SOURCE && $stable(cnt_pulse))
    else $error("pulse without threshold crossing");
  chk_vernier_slow: assert property (@(posedge CORE_CLK) disable iff (RESET)
    state == MSS_FAST && VERNIER_THRESHOLD_COMPARATOR && !BASELINE_REACHED
    |=> DISCHARGE_SLOW && DISCHARGE_CURRENT_SOURCE && state == MSS_SLOW)
    else $error("vernier current not selected");
  chk_vern_separate: assert property (@(posedge CORE_CLK) disable iff (RESET)
    state == MSS_FAST && !conv_clr |=> $stable(cnt_vern))
    else $error("vernier counter moved in fast rundown");
  chk_baseline_stop: assert property (@(posedge CORE_CLK) disable iff (RESET)
    conv_end |=> !DISCHARGE_CURRENT_SOURCE && !DISCHARGE_SLOW ##1 !DISCHARGE_CURRENT_SOURCE)
    else $error("rundown did not stop at baseline");
  chk_offset_first: assert property (@(posedge CORE_CLK) disable iff (RESET)
    $rose(BUSY) |-> PHASE == MSS_PH_OFFSET && INTEGRATE)
    else $error("measurement did not begin with offset cycle");
  chk_done_hold: assert property (@(posedge CORE_CLK) disable iff (RESET)
    DONE |=> $stable(res[0]) && $stable(res[1]) && $stable(res[2]) && !BUSY)
    else $error("results moved while complete");

  cov_pulse: cover property (@(posedge CORE_CLK) disable iff (RESET) pulse_go);
  cov_vernier: cover property (@(posedge CORE_CLK) disable iff (RESET) $rose(DISCHARGE_SLOW));
  cov_done: cover property (@(posedge CORE_CLK) disable iff (RESET) $rose(DONE));
  cov_range_err: cover property (@(posedge CORE_CLK) disable iff (RESET) $rose(RANGE_ERR));

endmodule

// >>> tb/mss_integrator_model.sv
module mss_integrator_model #(
  parameter int FULL_RATE = 128,
  parameter int UPPER_LVL = 1000,
  parameter int VERN_LVL  = 256
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       integrate,
  input  wire logic       sw_closed,
  input  wire logic       slow,
  input  wire logic [7:0] rate,
  output logic            upper,
  output logic            vernier,
  output logic            baseline
);
  timeunit 1ns;
  timeprecision 1ns;
  int level;
  // residue below baseline is kept, as a real integrator would keep it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level <= 0;
    end else begin
      level <= level + (integrate ? int'(rate) : 0) - (sw_closed ? (slow ? 1 : FULL_RATE) : 0);
    end
  end
  assign upper    = level >= UPPER_LVL;
  assign vernier  = !integrate && level <= VERN_LVL;
  assign baseline = !integrate && level <= 0;
endmodule

// >>> tb/mss_sequencer_tb.sv
module mss_sequencer_tb
  import mss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MINC = 200;
  localparam int MAXC = 2000;
  localparam int TD   = 16;
  localparam int UPPER = 1000;
  logic        clk = 0, rst = 1, start = 0, ack = 0;
  logic [21:0] per = '0;
  logic [1:0]  sel = '0;
  logic [7:0]  rate = '0;
  logic        up, vern, base, integ, sw, slow, busy, done, rerr;
  mss_phase_t  phase;
  mss_result_t res;
  int          errors = 0, cmp_count = 0, cyc = 0;
  int          q[$];
  int          il, sl, pc, fn, vn, idx;
  logic        pi = 0, ps = 0, rd_end;
  logic [31:0] seed = 32'h45A4;
  mss_result_t obs[3];

  always #50 clk = ~clk;

  mss_sequencer #(.CHARGE_MIN_CYC(MINC), .CHARGE_MAX_CYC(MAXC), .FIXED_DISCHARGE_INTERVAL(TD)) mss_sequencer_i (
    .CORE_CLK(clk), .RESET(rst), .START(start), .RESULT_ACK(ack), .TEST_PERIOD_CYC(per),
    .RESULT_SEL(sel), .UPPER_THRESHOLD_COMPARATOR(up), .VERNIER_THRESHOLD_COMPARATOR(vern),
    .BASELINE_REACHED(base), .INTEGRATE(integ), .DISCHARGE_CURRENT_SOURCE(sw), .DISCHARGE_SLOW(slow),
    .BUSY(busy), .DONE(done), .RANGE_ERR(rerr), .PHASE(phase), .RESULT(res));

  mss_integrator_model #(.UPPER_LVL(UPPER)) mss_integrator_model_i (
    .clk(clk), .rst(rst), .integrate(integ), .sw_closed(sw), .slow(slow), .rate(rate),
    .upper(up), .vernier(vern), .baseline(base));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // tick phase and state boundaries leave a small slack
  task automatic tol(input logic [23:0] seen, input int n);
    int   e;
    logic ok;
    e  = n * 2 / 5;
    ok = ({8'h0, seen} + 32'h2 >= e) && ({8'h0, seen} <= e + 2);
    check(ok, 1'b1);
  endtask

  task automatic conclude;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog: a hang still reaches the verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      conclude;
    end
  end

  // port watcher: charge length against driver notes, observed counts per cycle
  // a rundown ends as charge restarts or busy drops; any other opening ends a
  // fixed pulse, also one still running after charge, which is not fast rundown
  always @(posedge clk) begin
    rd_end = !sw && ps && (!busy || (integ && !pi));
    if (!sw && ps && !rd_end) check(sl, TD);
    if (rd_end && idx < 3) begin
      obs[idx] = {pc[23:0], fn[23:0], vn[23:0]};
      idx++;
    end
    if (!busy) idx = 0;
    if (integ && !pi) begin
      check(phase, idx);
      il = 0;
      pc = 0;
      fn = 0;
      vn = 0;
    end
    if (sw && !ps) sl = 0;
    if (sw && !ps && !integ) fn = 0;
    if (integ) il++;
    if (sw) sl++;
    if (sw && !slow && !integ) fn++;
    if (slow) vn++;
    if (sw && !ps && pi) pc++;
    if (!integ && pi) check(il, q.size() > 0 ? q.pop_front() : -1);
    pi = integ;
    ps = sw;
  end

  task automatic readback;
    for (int s = 0; s < 4; s++) begin
      @(posedge clk) sel <= s[1:0];
      repeat (2) @(posedge clk);
      #1;
      if (s == 3) begin
        check(res, '0);
      end else begin
        check(res.pulses, obs[s].pulses);
        tol(res.fast, obs[s].fast);
        tol(res.vernier, obs[s].vernier);
      end
    end
  endtask

  task automatic run(input logic [21:0] p, input logic [7:0] r);
    int k;
    @(posedge clk);
    per   <= p;
    rate  <= r;
    start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    #1;
    if (p == 0 || p > MAXC - MINC) begin
      check({rerr, busy}, 2'b10);
    end else begin
      check({busy, integ, rerr}, 3'b110);
      k = (MINC + p - 1) / p;
      repeat (3) q.push_back(k * p);
      // a second request while busy, with another period, is ignored
      @(posedge clk) start <= 1'b1;
      per <= 22'h5;
      @(posedge clk) start <= 1'b0;
      for (int i = 0; i < 20000 && done !== 1'b1; i++) @(posedge clk) #1;
      #1;
      check({done, busy}, 2'b10);
      @(posedge clk) start <= 1'b1;
      @(posedge clk) start <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check({done, busy}, 2'b10);
      readback;
      // from a drained start, charge too small to reach the upper level fires no pulse
      if (int'(r) * k * int'(p) < UPPER) check({obs[0].pulses, obs[1].pulses, obs[2].pulses}, '0);
      @(posedge clk) ack <= 1'b1;
      @(posedge clk) ack <= 1'b0;
      #1;
      check(done, 1'b0);
      check(q.size(), 0);
    end
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    check({busy, done, rerr, integ, sw, slow, phase}, '0);
    check(res, '0);
    run(22'h0, 8'h5);
    run(22'h709, 8'h5);
    run(22'h7, 8'h0);
    run(22'hC8, 8'h3);
    run(22'h708, 8'h1);
    run(22'h9, 8'h1F);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      run(22'(seed % 300 + 1), {3'h0, seed[12:8]});
    end
    conclude;
  end
endmodule
